// ==== include/stack_select_pkg.sv ====
// Package for the stacked-die bus select block
package stack_select_pkg;

  localparam int DATA_WIDTH = 16;
  localparam int ADDR_WIDTH = 26;
  localparam int FLASH_DIES = 3;
  localparam int PSRAM_DIES = 2;

  // Top word-address bit per flash die density
  localparam int TOP_BIT_LARGE  = 22;
  localparam int TOP_BIT_MIDDLE = 21;
  localparam int TOP_BIT_SMALL  = 20;

  // Reserved high-order address field
  localparam int RSVD_ADDR_LO = 24;
  localparam int RSVD_ADDR_HI = 25;

  // Density codes
  localparam logic [1:0] DENS_SMALL  = 2'h0;
  localparam logic [1:0] DENS_MIDDLE = 2'h1;
  localparam logic [1:0] DENS_LARGE  = 2'h2;

  // Reset values
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_FLASH1,
    SRC_FLASH2,
    SRC_FLASH3,
    SRC_RAM
  } drive_src_e;

  // Host-side control pins, all active low except sramSelectHighTrue
  typedef struct packed {
    logic [2:0] flashSelectN;
    logic [1:0] flashOutGateN;
    logic       flashWriteN;
    logic       sramSelectLowTrue;
    logic       sramSelectHighTrue;
    logic [1:0] psramSelectN;
    logic       ramOutGateN;
    logic       ramWriteN;
  } ctrl_pins_s;

  // Per-die activity view
  typedef struct packed {
    logic [2:0] flashActive;
    logic       sramActive;
    logic [1:0] psramActive;
  } die_state_s;

endpackage

// ==== verilog/stacked_die_bus_select.sv ====
// Pin-level select, output gating and write capture of a multi-die memory stack
// Overview of operation
// R1 - Top word-address bit is 22, 21 or 20 by flash die density
// R2 - Address bit zero steps consecutive 16-bit words
// R3 - Address bits 25 and 24 are reserved and have no function
// R4 - Data bus carries writes inward and read data outward
// R5 - Flash die releases data bus when deselected or outputs disabled
// R6 - Flash die latches write data internally each write cycle
// R7 - Low flash select activates that die
// R8 - High flash select gives standby, data and wait released
// R9 - Three flash selects, one per die; extra ones unused
// R10 - SRAM has one low-true and one high-true select
// R11 - Either SRAM select deasserted deselects SRAM into standby
// R12 - Each low-true PSRAM select addresses one PSRAM die
// R13 - Low PSRAM select activates die; high gives standby
// R14 - Low flash output gate enables selected die buffers
// R15 - Gate one serves die one; gate two serves dies two and three
// R16 - Low RAM output gate enables selected RAM buffers
// R17 - Flash write strobe low-true; capture on rising edge
// R18 - Wait released when die deselected; not gated by output gate
// R19 - Low-true RAM write strobe writes the selected RAM die; code writes only while the RAM output gate is high
// R20 - Host never enables two dies onto the data bus together
`timescale 1ns/1ps
`default_nettype none
module stacked_die_bus_select
  import stack_select_pkg::*;
#(
  parameter int          FLASH_COUNT = FLASH_DIES,
  parameter int          PSRAM_COUNT = PSRAM_DIES,
  parameter logic        HAS_SRAM    = 1'b1,
  parameter logic [1:0]  DENSITY     = DENS_LARGE,
  parameter int          WORDS       = 64
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // Host pins
  input  wire logic [ADDR_WIDTH-1:0]  addrPins,
  input  wire ctrl_pins_s             ctrlPins,
  input  wire logic [DATA_WIDTH-1:0]  dataIn,
  // Data bus drive
  output logic      [DATA_WIDTH-1:0]  dataOut,
  output logic                        dataOeN,
  // Flash wait indicator
  output logic                        waitOut,
  output logic                        waitOeN,
  // Die activity and top address bit
  output die_state_s                  dieState,
  output logic      [4:0]             top_address_bit
);

  localparam int AW = $clog2(WORDS);

  // Pin synchronisers
  logic [ADDR_WIDTH-1:0] addrMeta, addrSync;
  ctrl_pins_s            ctrlMeta, ctrlSync, ctrlPrev;
  logic [DATA_WIDTH-1:0] dataMeta, dataSync;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addrMeta <= '0;
      addrSync <= '0;
      ctrlMeta <= '1;
      ctrlSync <= '1;
      ctrlPrev <= '1;
      dataMeta <= DATA_RESET;
      dataSync <= DATA_RESET;
    end else begin
      addrMeta <= addrPins;
      addrSync <= addrMeta;
      ctrlMeta <= ctrlPins;
      ctrlSync <= ctrlMeta;
      ctrlPrev <= ctrlSync;
      dataMeta <= dataIn;
      dataSync <= dataMeta;
    end
  end

  // Density decode
  function automatic logic [4:0] top_bit(input logic [1:0] dens);
    case (dens)
      DENS_LARGE:  top_bit = 5'(TOP_BIT_LARGE);
      DENS_MIDDLE: top_bit = 5'(TOP_BIT_MIDDLE);
      default:     top_bit = 5'(TOP_BIT_SMALL);
    endcase
  endfunction

  wire logic [4:0] topBit = top_bit(DENSITY); // [R1]
  // Word index within the modelled array; bits 25:24 never decoded
  wire logic [AW-1:0] wordIdx = addrSync[AW-1:0]; // [R2] [R3]

  // Die selection
  wire logic [2:0] flashAvail = 3'((4'h1 << FLASH_COUNT) - 4'h1);
  wire logic [1:0] psramAvail = 2'((3'h1 << PSRAM_COUNT) - 3'h1);
  wire logic [2:0] flashSel   = ~ctrlSync.flashSelectN & flashAvail; // [R7] [R9]
  wire logic       sramSel    = HAS_SRAM & ~ctrlSync.sramSelectLowTrue
                                & ctrlSync.sramSelectHighTrue; // [R10] [R11]
  wire logic [1:0] psramSel   = ~ctrlSync.psramSelectN & psramAvail; // [R12] [R13]
  wire logic       ramPresent = HAS_SRAM | (PSRAM_COUNT > 0);
  wire logic       ramSel     = ramPresent & (sramSel | (|psramSel));

  // Output gates: gate two shared by dies two and three
  wire logic [2:0] flashGate = {~ctrlSync.flashOutGateN[1], ~ctrlSync.flashOutGateN[1],
                                ~ctrlSync.flashOutGateN[0]}; // [R15]
  wire logic [2:0] flashDrv  = flashSel & flashGate; // [R5] [R14]
  wire logic       ramDrv    = ramSel & ~ctrlSync.ramOutGateN; // [R16]

  // Write strobes: rising edge of flash strobe, low level of RAM strobe
  wire logic flashWrRise = ctrlSync.flashWriteN & ~ctrlPrev.flashWriteN; // [R17]
  wire logic ramWrite    = ramSel & ~ctrlSync.ramWriteN & ctrlSync.ramOutGateN; // [R19]

  // Storage per flash die; one array shared by all RAM dies
  logic [DATA_WIDTH-1:0] flashMem [FLASH_DIES][WORDS];
  logic [DATA_WIDTH-1:0] ramMem   [WORDS];
  logic [DATA_WIDTH-1:0] wrLatch;
  logic [AW-1:0]         wrAddr;

  // Write data latched while strobe low, committed on rising edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wrLatch <= DATA_RESET;
      wrAddr  <= '0;
    end else if (!ctrlSync.flashWriteN) begin
      wrLatch <= dataSync; // [R6]
      wrAddr  <= wordIdx;
    end
  end

  genvar g;
  generate
    for (g = 0; g < FLASH_DIES; g++) begin : g_flash
      always_ff @(posedge sys_clk) begin
        if (flashWrRise && ctrlPrev.flashSelectN[g] == 1'b0 && flashAvail[g]) begin
          flashMem[g][wrAddr] <= wrLatch; // [R6] [R17]
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (ramWrite) begin
      ramMem[wordIdx] <= dataSync; // [R4] [R19]
    end
  end

  // Source select; host keeps a single driver
  drive_src_e src;
  always_comb begin
    case (1'b1)
      flashDrv[0]: src = SRC_FLASH1;
      flashDrv[1]: src = SRC_FLASH2;
      flashDrv[2]: src = SRC_FLASH3;
      ramDrv:      src = SRC_RAM;
      default:     src = SRC_NONE;
    endcase
  end

  logic [DATA_WIDTH-1:0] next_dataOut;
  always_comb begin
    case (src)
      SRC_FLASH1: next_dataOut = flashMem[0][wordIdx];
      SRC_FLASH2: next_dataOut = flashMem[1][wordIdx];
      SRC_FLASH3: next_dataOut = flashMem[2][wordIdx];
      SRC_RAM:    next_dataOut = ramMem[wordIdx];
      default:    next_dataOut = DATA_RESET;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dataOut         <= DATA_RESET;
      dataOeN         <= 1'b1;
      waitOut         <= 1'b0;
      waitOeN         <= 1'b1;
      dieState        <= '0;
      top_address_bit <= 5'(TOP_BIT_SMALL);
    end else begin
      dataOut         <= next_dataOut; // [R4]
      dataOeN         <= (src == SRC_NONE); // [R5] [R8] [R14] [R16]
      waitOut         <= 1'b0;
      waitOeN         <= ~(|flashSel); // [R8] [R18]
      dieState        <= '{flashActive: flashSel, sramActive: sramSel,
                           psramActive: psramSel}; // [R7] [R11] [R13]
      top_address_bit <= topBit; // [R1]
    end
  end

  // Assertions
  sequence s_flash_off;
    ctrlSync.flashSelectN == 3'h7;
  endsequence

  sequence s_strobe_rise;
    !ctrlSync.flashWriteN ##1 ctrlSync.flashWriteN;
  endsequence

  sequence s_flash1_read;
    !ctrlSync.flashSelectN[0] && !ctrlSync.flashOutGateN[0];
  endsequence

  property p_float_deselect;
    @(posedge sys_clk) disable iff (!rstn)
      s_flash_off and !ramDrv |=> dataOeN;
  endproperty
  a_float_deselect: assert property (p_float_deselect) else $error("bus driven while idle"); // [R5]

  property p_gate_off;
    @(posedge sys_clk) disable iff (!rstn)
      ctrlSync.flashOutGateN == 2'h3 && !ramDrv |=> dataOeN;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("bus driven with gates high"); // [R14]

  property p_flash1_drive;
    @(posedge sys_clk) disable iff (!rstn)
      !ctrlSync.flashSelectN[0] && !ctrlSync.flashOutGateN[0] |=> !dataOeN;
  endproperty
  a_flash1_drive: assert property (p_flash1_drive) else $error("die one not driving"); // [R7]

  property p_wait_release;
    @(posedge sys_clk) disable iff (!rstn)
      s_flash_off |=> waitOeN;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait driven when idle"); // [R8]

  property p_wait_ungated;
    @(posedge sys_clk) disable iff (!rstn)
      !ctrlSync.flashSelectN[0] && ctrlSync.flashOutGateN[0] |=> !waitOeN;
  endproperty
  a_wait_ungated: assert property (p_wait_ungated) else $error("wait gated by output gate"); // [R18]

  property p_sram_standby;
    @(posedge sys_clk) disable iff (!rstn)
      ctrlSync.sramSelectLowTrue || !ctrlSync.sramSelectHighTrue |=> !dieState.sramActive;
  endproperty
  a_sram_standby: assert property (p_sram_standby) else $error("sram not in standby"); // [R11]

  property p_psram_select;
    @(posedge sys_clk) disable iff (!rstn)
      !ctrlSync.psramSelectN[0] |=> dieState.psramActive[0];
  endproperty
  a_psram_select: assert property (p_psram_select) else $error("psram not active"); // [R13]

  property p_ram_gate;
    @(posedge sys_clk) disable iff (!rstn)
      ctrlSync.ramOutGateN && flashDrv == 3'h0 |=> dataOeN;
  endproperty
  a_ram_gate: assert property (p_ram_gate) else $error("ram driving with gate high"); // [R16]

  property p_top_bit;
    @(posedge sys_clk) disable iff (!rstn)
      1'b1 |=> top_address_bit == top_bit(DENSITY);
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("wrong top address bit"); // [R1]

  property p_latch_hold;
    @(posedge sys_clk) disable iff (!rstn)
      !ctrlSync.flashWriteN ##1 ctrlSync.flashWriteN |=> $stable(wrLatch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("write latch changed"); // [R6]

  property p_flash2_drive;
    @(posedge sys_clk) disable iff (!rstn)
      flashAvail[1] && !ctrlSync.flashSelectN[1] && !ctrlSync.flashOutGateN[1] |=> !dataOeN;
  endproperty
  a_flash2_drive: assert property (p_flash2_drive) else $error("die two not driving"); // [R15]

  property p_flash3_drive;
    @(posedge sys_clk) disable iff (!rstn)
      flashAvail[2] && !ctrlSync.flashSelectN[2] && !ctrlSync.flashOutGateN[1] |=> !dataOeN;
  endproperty
  a_flash3_drive: assert property (p_flash3_drive) else $error("die three not driving"); // [R15]

  property p_gate_cross;
    @(posedge sys_clk) disable iff (!rstn)
      ctrlSync.flashSelectN[0] && ctrlSync.flashOutGateN[1] && !ramDrv |=> dataOeN;
  endproperty
  a_gate_cross: assert property (p_gate_cross) else $error("gate one drove die two"); // [R15]

  property p_ram_drive;
    @(posedge sys_clk) disable iff (!rstn)
      ramSel && !ctrlSync.ramOutGateN |=> !dataOeN;
  endproperty
  a_ram_drive: assert property (p_ram_drive) else $error("ram not driving"); // [R16]

  property p_flash_active;
    @(posedge sys_clk) disable iff (!rstn)
      1'b1 |=> dieState.flashActive == $past(flashSel);
  endproperty
  a_flash_active: assert property (p_flash_active) else $error("flash activity wrong"); // [R7]

  property p_flash_standby;
    @(posedge sys_clk) disable iff (!rstn)
      s_flash_off |=> dieState.flashActive == 3'h0;
  endproperty
  a_flash_standby: assert property (p_flash_standby) else $error("flash not in standby"); // [R8]

  property p_wait_drive;
    @(posedge sys_clk) disable iff (!rstn)
      ctrlSync.flashSelectN != 3'h7 |=> !waitOeN;
  endproperty
  a_wait_drive: assert property (p_wait_drive) else $error("wait not driven"); // [R18]

  property p_sram_active;
    @(posedge sys_clk) disable iff (!rstn)
      HAS_SRAM && !ctrlSync.sramSelectLowTrue && ctrlSync.sramSelectHighTrue
        |=> dieState.sramActive;
  endproperty
  a_sram_active: assert property (p_sram_active) else $error("sram not active"); // [R10]

  property p_psram2_select;
    @(posedge sys_clk) disable iff (!rstn)
      psramAvail[1] && !ctrlSync.psramSelectN[1] |=> dieState.psramActive[1];
  endproperty
  a_psram2_select: assert property (p_psram2_select) else $error("psram two idle"); // [R12]

  property p_psram_standby;
    @(posedge sys_clk) disable iff (!rstn)
      ctrlSync.psramSelectN[0] |=> !dieState.psramActive[0];
  endproperty
  a_psram_standby: assert property (p_psram_standby) else $error("psram not standby"); // [R13]

  property p_latch_follow;
    @(posedge sys_clk) disable iff (!rstn)
      !ctrlSync.flashWriteN |=> wrLatch == $past(dataSync);
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("write data not latched"); // [R6]

  property p_flash_commit;
    @(posedge sys_clk) disable iff (!rstn)
      s_strobe_rise ##0 !ctrlPrev.flashSelectN[0] |=> flashMem[0][wrAddr] == wrLatch;
  endproperty
  a_flash_commit: assert property (p_flash_commit) else $error("flash word not stored"); // [R17]

  property p_ram_store;
    @(posedge sys_clk) disable iff (!rstn)
      ramWrite |=> ramMem[$past(wordIdx)] == $past(dataSync);
  endproperty
  a_ram_store: assert property (p_ram_store) else $error("ram word not stored"); // [R19]

  property p_read_data;
    @(posedge sys_clk) disable iff (!rstn)
      s_flash1_read |=> dataOut == $past(flashMem[0][wordIdx]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("wrong read data"); // [R4]

endmodule
`default_nettype wire

// ==== tb/stack_host_model.sv ====
// Host memory controller model driving the shared stack pins
`timescale 1ns/1ps
`default_nettype none
module stack_host_model
  import stack_select_pkg::*;
(
  // Clock
  input  wire logic                  sys_clk,
  // Host pins
  output logic      [ADDR_WIDTH-1:0] addrPins,
  output ctrl_pins_s                 ctrlPins,
  output logic      [DATA_WIDTH-1:0] dataIn
);
  // All dies deselected, gates and strobes high
  localparam ctrl_pins_s IDLE = ctrl_pins_s'(12'hFEF);

  initial begin
    addrPins = '0;
    ctrlPins = IDLE;
    dataIn   = '0;
  end

  // Word address on the pins, held for n edges
  task automatic put(input ctrl_pins_s c, input logic [25:0] a, input logic [15:0] d,
                     input int n);
    ctrlPins = c;
    addrPins = a;
    dataIn   = d;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic flash_write(input int die, input logic [25:0] a, input logic [15:0] d);
    ctrl_pins_s c;
    c = IDLE;
    c.flashSelectN[die] = 1'b0;
    c.flashWriteN = 1'b0;
    put(c, a, d, 4);
    c.flashWriteN = 1'b1;
    put(c, a, d, 3);
    put(IDLE, a, ~d, 1);
  endtask

  // One die and one gate only on the shared bus
  task automatic flash_read(input int die, input logic [25:0] a);
    ctrl_pins_s c;
    c = IDLE;
    c.flashSelectN[die] = 1'b0;
    c.flashOutGateN[die == 0 ? 0 : 1] = 1'b0;
    put(c, a, ~dataIn, 4);
  endtask

  task automatic ram_access(input logic wr, input logic [25:0] a, input logic [15:0] d);
    ctrl_pins_s c;
    c = IDLE;
    c.sramSelectLowTrue  = 1'b0;
    c.sramSelectHighTrue = 1'b1;
    c.ramWriteN   = ~wr;
    c.ramOutGateN = wr;
    put(c, a, d, 4);
  endtask
endmodule
`default_nettype wire

// ==== tb/test_stacked_die_bus_select.sv ====
// Self-checking testbench for the stacked-die bus select block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module test_stacked_die_bus_select;
  import stack_select_pkg::*;
  logic                  sys_clk;
  logic                  rstn;
  logic [ADDR_WIDTH-1:0] addrPins;
  ctrl_pins_s            ctrlPins;
  logic [DATA_WIDTH-1:0] dataIn;
  logic [DATA_WIDTH-1:0] dataOut;
  logic                  dataOeN;
  logic                  waitOut;
  logic                  waitOeN;
  die_state_s            dieState;
  logic [4:0]            topBit;
  int                    errors;
  int                    compares;
  int                    cycles;
  int                    die;
  logic [25:0]           a;
  logic [15:0]           d;
  ctrl_pins_s            c;

  stacked_die_bus_select i_dut (.sys_clk(sys_clk), .rstn(rstn), .addrPins(addrPins),
    .ctrlPins(ctrlPins), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
    .waitOut(waitOut), .waitOeN(waitOeN), .dieState(dieState), .top_address_bit(topBit));
  stack_host_model i_host (.sys_clk(sys_clk), .addrPins(addrPins), .ctrlPins(ctrlPins),
    .dataIn(dataIn));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Expected die activity from the select pins
  function automatic die_state_s exp_state(input ctrl_pins_s p);
    return {~p.flashSelectN, ~p.sramSelectLowTrue & p.sramSelectHighTrue, ~p.psramSelectN};
  endfunction

  // Random word address inside the array, reserved bits random
  function automatic logic [25:0] rnd_addr();
    return {2'($urandom), 18'h00000, 6'($urandom)};
  endfunction

  task automatic end_sim;
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    rstn = 1'b0;
    errors = 0;
    compares = 0;
    cycles = 0;
    void'($urandom(36571));
    repeat (16) @(posedge sys_clk);
    #1;
    `CHECK({dataOeN, waitOeN, dieState}, 8'hC0)
    rstn = 1'b1;
    @(posedge sys_clk);
    #1;
    `CHECK(topBit, 5'h16)
    // Consecutive word addresses hold separate words
    i_host.flash_write(0, 26'h0000005, 16'hA5C3);
    i_host.flash_write(0, 26'h0000006, 16'h3C5A);
    i_host.flash_read(0, 26'h0000005);
    `CHECK(dataOut, 16'hA5C3)
    i_host.flash_read(0, 26'h0000006);
    `CHECK(dataOut, 16'h3C5A)
    for (int i = 0; i < 12; i++) begin
      die = $urandom_range(2, 0);
      a = rnd_addr();
      d = 16'($urandom);
      i_host.flash_write(die, a, d);
      i_host.flash_read(die, {~a[25:24], a[23:0]});
      `CHECK({dataOeN, waitOeN, dataOut}, {2'h0, d})
      `CHECK(dieState.flashActive, 3'(1 << die))
      c = ctrlPins;
      c.flashOutGateN = 2'h3;
      i_host.put(c, a, ~d, 4);
      `CHECK({dataOeN, waitOeN}, 2'h2)
      c.flashOutGateN = (die == 0) ? 2'h1 : 2'h2;
      i_host.put(c, a, d, 4);
      `CHECK({dataOeN, waitOeN, waitOut}, 3'h4)
      c = ctrl_pins_s'(12'hFEF);
      c.flashOutGateN = 2'h0;
      i_host.put(c, a, d, 4);
      `CHECK({dataOeN, waitOeN, dieState.flashActive}, 5'h18)
      a = rnd_addr();
      d = 16'($urandom);
      i_host.ram_access(1'b1, a, d);
      i_host.ram_access(1'b0, a, ~d);
      `CHECK({dataOeN, dataOut}, {1'b0, d})
    end
    // Every select combination for flash, SRAM and PSRAM dies
    for (int i = 0; i < 8; i++) begin
      c = ctrl_pins_s'(12'hFEF);
      c.flashSelectN = 3'(i);
      c.psramSelectN = 2'(i);
      c.sramSelectLowTrue = i[0];
      c.sramSelectHighTrue = i[1];
      i_host.put(c, rnd_addr(), 16'($urandom), 4);
      `CHECK(dieState, exp_state(c))
      `CHECK(dataOeN, 1'b1)
    end
    end_sim();
  end
endmodule
`default_nettype wire
